// file: rtl/eeo_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module eeo_buf2
  import eeo_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  // ==========================================
  // storage
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_q, rp_q;
  logic [$clog2(DEPTH):0]   cnt_q, cnt_d;
  logic push, pop;
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rp_q];
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    if (pop && !push) cnt_d = cnt_q - 1'b1;
  end
  // ready and valid are registered so the source sees honest flags
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wp_q        <= '0;
      rp_q        <= '0;
      cnt_q       <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        mem_q[wp_q] <= i_in_data;
        wp_q        <= wp_q + 1'b1;
      end
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q       <= cnt_d;
      o_in_ready  <= (cnt_d != DEPTH[$clog2(DEPTH):0]);
      o_out_valid <= (cnt_d != '0);
    end
  end
endmodule
`default_nettype wire

// file: rtl/eeo_encoder_emulation.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: position comes from absolute feedback samples
// RULE2: function 1 drives quadrature on output
// RULE3: channels a and b ninety degrees apart
// RULE4: line count limits depend on feedback type
// RULE5: one zero pulse per turn, a=b=1
// RULE6: interpolation 4..128 lines, zero passed through
// RULE7: stored offset places zero pulse anywhere
// RULE8: serial mode sends 24 data bits
// RULE9: single-turn: upper twelve bits zero
// RULE10: single-turn range scales with resolver poles
// RULE11: commutation track unhomed: upper bits ones
// RULE12: multi-turn: upper twelve bits count turns
// RULE13: gray code default, binary when selected
// RULE14: 200 khz or 1.5 mhz, optional inversion
// RULE15: value counts up turning clockwise
// RULE16: idle monoflop time before next frame
// RULE17: first edge latches, msb shifted first
// RULE18: a leads b clockwise, reversed otherwise
module eeo_encoder_emulation
  import eeo_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic                i_pos_valid,
  input  wire logic [ANGLE_W-1:0]  i_pos_angle,
  input  wire logic [TURNS_W-1:0]  i_pos_turns,
  output logic                     o_pos_ready,
  input  wire logic [PHASE_W-1:0]  i_sine_phase,
  input  wire logic                i_sine_zero,
  input  wire logic [1:0]          i_encoder_output_function,
  input  wire logic                i_feedback_is_encoder,
  input  wire logic [5:0]          i_resolver_poles,
  input  wire logic                i_comm_track,
  input  wire logic                i_homing_done,
  input  wire logic [LINES_W-1:0]  i_line_count,
  input  wire logic [INTERP_W-1:0] i_interp_lines,
  input  wire logic [ANGLE_W-1:0]  i_zero_marker_offset,
  input  wire logic                i_multi_turn,
  input  wire logic                i_serial_code_select,
  input  wire logic                i_serial_clock_rate_select,
  input  wire logic                i_serial_clock_invert,
  input  wire logic                i_ssi_clk,
  output logic                     o_ssi_data,
  output logic                     o_ssi_busy,
  output logic                     o_enc_a,
  output logic                     o_enc_b,
  output logic                     o_enc_zero,
  output logic                     o_line_count_bad
);
  // ==========================================
  // feedback samples through the two-entry buffer
  logic                     fb_valid, fb_take, quad_done;
  logic [ANGLE_W+TURNS_W-1:0] fb_data;
  logic [ANGLE_W-1:0]       angle_q;
  logic [TURNS_W-1:0]       turns_q;
  logic [1:0]               fn;
  assign fn = i_encoder_output_function;
  // in incremental mode, hold off new samples while the pulse train still catches up
  assign fb_take = (fn != FN_INCR) || quad_done; //RULE1
  eeo_buf2 #(
    .WIDTH (ANGLE_W + TURNS_W),
    .DEPTH (2)
  ) u_buf (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_in_valid  (i_pos_valid),
    .i_in_data   ({i_pos_turns, i_pos_angle}),
    .o_in_ready  (o_pos_ready),
    .o_out_valid (fb_valid),
    .o_out_data  (fb_data),
    .i_out_ready (fb_take)
  );
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      angle_q <= '0;
      turns_q <= '0;
    end else if (i_ce && fb_valid && fb_take) begin
      angle_q <= fb_data[ANGLE_W-1:0]; //RULE1
      turns_q <= fb_data[ANGLE_W+TURNS_W-1:ANGLE_W];
    end
  end
  // ==========================================
  // pin synchronisers
  logic ck_s1_q, ck_s2_q, ck_prev_q, nz_s1_q, nz_s2_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ck_s1_q   <= 1'b1;
      ck_s2_q   <= 1'b1;
      ck_prev_q <= 1'b1;
      nz_s1_q   <= 1'b0;
      nz_s2_q   <= 1'b0;
    end else if (i_ce) begin
      ck_s1_q   <= i_ssi_clk;
      ck_s2_q   <= ck_s1_q;
      ck_prev_q <= ck_s2_q ^ i_serial_clock_invert; //RULE14
      nz_s1_q   <= i_sine_zero;
      nz_s2_q   <= nz_s1_q;
    end
  end
  // ==========================================
  // incremental target
  logic                 lines_ok, is_pow2, run;
  logic [LINES_W-1:0]   lines;
  logic [ANGLE_W-1:0]   frac;
  logic [ANGLE_W+LINES_W-1:0] prod;
  logic [QCNT_W-1:0]    target, total;
  logic                 qa, qb, qzero;
  always_comb begin
    is_pow2 = (i_line_count & (i_line_count - 1'b1)) == '0;
    if (fn == FN_INTERP) begin
      lines    = LINES_W'(i_interp_lines);
      frac     = {i_sine_phase, 8'h00};
      lines_ok = (i_interp_lines >= INTERP_MIN) &&
                 (i_interp_lines <= INTERP_MAX); //RULE6
    end else begin
      lines    = i_line_count;
      frac     = angle_q - i_zero_marker_offset; //RULE7
      if (i_feedback_is_encoder) begin //RULE4
        lines_ok = (i_line_count != '0) &&
                   ((i_line_count <= ENC_LINES_MAX) ||
                    (is_pow2 && i_line_count >= ENC_POW2_MIN &&
                     i_line_count <= ENC_POW2_MAX));
      end else begin
        lines_ok = (i_line_count != '0) &&
                   (i_line_count <= RES_LINES_MAX); //RULE4
      end
    end
    prod   = (ANGLE_W+LINES_W)'(frac) * (ANGLE_W+LINES_W)'(lines);
    target = prod[ANGLE_W+LINES_W-1:ANGLE_W-2];
    total  = {lines, 2'b00};
    run    = lines_ok && ((fn == FN_INCR) || (fn == FN_INTERP));
  end
  eeo_quad_step u_quad (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_run       (run),
    .i_target    (target),
    .i_total     (total),
    .o_a         (qa),
    .o_b         (qb),
    .o_at_zero   (qzero),
    .o_at_target (quad_done)
  );
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_enc_a          <= 1'b0;
      o_enc_b          <= 1'b0;
      o_enc_zero       <= 1'b0;
      o_line_count_bad <= 1'b0;
    end else if (i_ce) begin
      o_enc_a          <= run && qa; //RULE2
      o_enc_b          <= run && qb; //RULE2
      if (fn == FN_INTERP) begin
        o_enc_zero <= run && nz_s2_q; //RULE6
      end else begin
        o_enc_zero <= run && qzero && qa && qb; //RULE5
      end
      o_line_count_bad <= (fn == FN_INCR || fn == FN_INTERP) && !lines_ok;
    end
  end
  // ==========================================
  // serial position word
  logic [4:0]            pole_pairs;
  logic [ANGLE_W+4:0]    scaled;
  logic [TURNS_W-1:0]    upper;
  logic [SSI_BITS-1:0]   bin_word, word;
  always_comb begin
    // angle rises clockwise, so the word counts up the same way
    pole_pairs = i_feedback_is_encoder ? 5'h01 : i_resolver_poles[5:1];
    scaled = (ANGLE_W+5)'(angle_q) * (ANGLE_W+5)'(pole_pairs); //RULE10
    if (i_multi_turn) begin
      upper = turns_q; //RULE12
    end else if (i_comm_track && !i_homing_done) begin
      upper = UPPER_INVALID; //RULE11
    end else begin
      upper = UPPER_ZERO; //RULE9
    end
    bin_word = {upper, scaled[ANGLE_W-1:ANGLE_W-SSI_HALF]}; //RULE15
    word = i_serial_code_select ? bin_word
                                : bin_word ^ (bin_word >> 1); //RULE13
  end
  // ==========================================
  // serial shifter with monoflop
  eeo_ssi_st_t         st_q, st_d;
  logic [SSI_BITS-1:0] sr_q, sr_d;
  logic [MONO_W-1:0]   mono_q, mono_d, mono_len;
  logic                data_d, ck_now, ck_fall, ck_rise;
  always_comb begin
    ck_now   = ck_s2_q ^ i_serial_clock_invert; //RULE14
    ck_fall  = ck_prev_q && !ck_now;
    ck_rise  = !ck_prev_q && ck_now;
    mono_len = i_serial_clock_rate_select ? MONO_W'(MONO_FAST_CYC)
                                          : MONO_W'(MONO_SLOW_CYC);
    st_d   = st_q;
    sr_d   = sr_q;
    mono_d = mono_q;
    data_d = o_ssi_data;
    if (fn != FN_SSI) begin
      st_d   = SSI_IDLE;
      data_d = 1'b1;
    end else begin
      unique case (st_q)
        SSI_IDLE: begin
          data_d = 1'b1;
          if (ck_fall) begin
            st_d   = SSI_SHIFT;
            sr_d   = word; //RULE17
            mono_d = mono_len;
          end
        end
        SSI_SHIFT: begin
          if (ck_rise) begin
            data_d = sr_q[SSI_BITS-1]; //RULE8
            sr_d   = {sr_q[SSI_BITS-2:0], 1'b0}; //RULE17
            mono_d = mono_len;
          end else if (ck_fall) begin
            mono_d = mono_len; //RULE16
          end else if (mono_q != '0) begin
            mono_d = mono_q - 1'b1;
          end else begin
            st_d   = SSI_IDLE; //RULE16
            data_d = 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q       <= SSI_IDLE;
      sr_q       <= '0;
      mono_q     <= '0;
      o_ssi_data <= 1'b1;
      o_ssi_busy <= 1'b0;
    end else if (i_ce) begin
      st_q       <= st_d;
      sr_q       <= sr_d;
      mono_q     <= mono_d;
      o_ssi_data <= data_d;
      o_ssi_busy <= (st_d == SSI_SHIFT);
    end
  end
  // ==========================================
  // checks
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_zero_both_high: assert property (o_enc_zero && fn == FN_INCR //RULE5
    |-> o_enc_a && o_enc_b) else $error("zero pulse without a=b=1");
  a_quiet_in_ssi: assert property (fn == FN_SSI && i_ce //RULE2
    |=> !o_enc_a && !o_enc_b && !o_enc_zero) else $error("pulses in ssi");
  a_frame_latch: assert property (i_ce && fn == FN_SSI && //RULE17
    st_q == SSI_IDLE && ck_fall |=> st_q == SSI_SHIFT && sr_q == $past(word))
    else $error("frame start did not latch word");
  a_msb_first: assert property (i_ce && fn == FN_SSI && //RULE17
    st_q == SSI_SHIFT && ck_rise |=> o_ssi_data == $past(sr_q[SSI_BITS-1]))
    else $error("bit not shifted msb first");
  a_mono_hold: assert property (i_ce && fn == FN_SSI && //RULE16
    st_q == SSI_SHIFT && mono_q != '0 |=> st_q == SSI_SHIFT)
    else $error("monoflop ended early");
  a_idle_data_high: assert property (st_q == SSI_IDLE && $past(i_ce) //RULE16
    |-> o_ssi_data) else $error("idle line not high");
  a_single_upper: assert property (!i_multi_turn && //RULE9
    !(i_comm_track && !i_homing_done) |-> word[SSI_BITS-1:SSI_HALF] == '0)
    else $error("single-turn upper bits not zero");
  a_invalid_ones: assert property (!i_multi_turn && i_comm_track && //RULE11
    !i_homing_done |-> bin_word[SSI_BITS-1:SSI_HALF] == UPPER_INVALID)
    else $error("unhomed upper bits not ones");
  a_multi_turns: assert property (i_multi_turn //RULE12
    |-> bin_word[SSI_BITS-1:SSI_HALF] == turns_q)
    else $error("turn count missing");
  a_gray_msb: assert property (!i_serial_code_select //RULE13
    |-> word[SSI_BITS-1] == bin_word[SSI_BITS-1] &&
        word[0] == (bin_word[0] ^ bin_word[1])) else $error("gray wrong");
  c_frame: cover property (st_q == SSI_IDLE ##1 st_q == SSI_SHIFT);
  c_zero: cover property (fn == FN_INCR && o_enc_zero);
  c_buf_full: cover property (i_pos_valid && !o_pos_ready);
  c_interp_zero: cover property (fn == FN_INTERP && o_enc_zero);
endmodule
`default_nettype wire

// file: rtl/eeo_pkg.sv
package eeo_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int EDGE_GAP_NS    = 200;
  localparam int EDGE_GAP_CYC   = (EDGE_GAP_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int MONO_SLOW_NS   = 13000;
  localparam int MONO_FAST_NS   = 3000;
  localparam int MONO_SLOW_CYC  = (MONO_SLOW_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int MONO_FAST_CYC  = (MONO_FAST_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  // ==========================================
  // widths
  localparam int ANGLE_W        = 24;
  localparam int TURNS_W        = 12;
  localparam int LINES_W        = 20;
  localparam int QCNT_W         = 22;
  localparam int SSI_BITS       = 24;
  localparam int SSI_HALF       = 12;
  localparam int PHASE_W        = 16;
  localparam int INTERP_W       = 8;
  localparam int GAP_W          = 5;
  localparam int MONO_W         = 11;
  // ==========================================
  // encoder output function codes
  localparam logic [1:0] FN_OFF    = 2'h0;
  localparam logic [1:0] FN_INCR   = 2'h1;
  localparam logic [1:0] FN_SSI    = 2'h2;
  localparam logic [1:0] FN_INTERP = 2'h3;
  // ==========================================
  // line count limits
  localparam logic [LINES_W-1:0] RES_LINES_MAX  = 20'h00400;
  localparam logic [LINES_W-1:0] ENC_LINES_MAX  = 20'h01000;
  localparam logic [LINES_W-1:0] ENC_POW2_MIN   = 20'h02000;
  localparam logic [LINES_W-1:0] ENC_POW2_MAX   = 20'h80000;
  localparam logic [INTERP_W-1:0] INTERP_MIN    = 8'h04;
  localparam logic [INTERP_W-1:0] INTERP_MAX    = 8'h80;
  // ==========================================
  // upper twelve bit values
  localparam logic [TURNS_W-1:0] UPPER_INVALID  = 12'hfff;
  localparam logic [TURNS_W-1:0] UPPER_ZERO     = 12'h000;
  typedef enum logic {SSI_IDLE, SSI_SHIFT} eeo_ssi_st_t;
endpackage

// file: rtl/eeo_quad_step.sv
`timescale 1ns/1ps
`default_nettype none
module eeo_quad_step
  import eeo_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  input  wire logic              i_run,
  input  wire logic [QCNT_W-1:0] i_target,
  input  wire logic [QCNT_W-1:0] i_total,
  output logic                   o_a,
  output logic                   o_b,
  output logic                   o_at_zero,
  output logic                   o_at_target
);
  // ==========================================
  // step toward target by the shorter way
  logic [QCNT_W-1:0] cur_q, cur_d, diff;
  logic [GAP_W-1:0]  gap_q, gap_d;
  logic              up, step;
  always_comb begin
    diff = (i_target >= cur_q) ? i_target - cur_q
                               : i_target + i_total - cur_q;
    up   = diff <= (i_total >> 1);
    step = i_run && (gap_q == '0) && (cur_q != i_target);
    cur_d = cur_q;
    gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
    if (cur_q >= i_total) begin
      cur_d = '0;
    end else if (step) begin
      gap_d = GAP_W'(EDGE_GAP_CYC - 1);
      if (up) begin //RULE18
        cur_d = (cur_q == i_total - 1'b1) ? '0 : cur_q + 1'b1;
      end else begin
        cur_d = (cur_q == '0) ? i_total - 1'b1 : cur_q - 1'b1;
      end
    end
  end
  // count zero is phase 11, counting up makes a lead b
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cur_q       <= '0;
      gap_q       <= '0;
      o_a         <= 1'b1;
      o_b         <= 1'b1;
      o_at_zero   <= 1'b0;
      o_at_target <= 1'b0;
    end else if (i_ce) begin
      cur_q       <= cur_d;
      gap_q       <= gap_d;
      o_a         <= (cur_d[1:0] == 2'h0) || (cur_d[1:0] == 2'h3); //RULE3
      o_b         <= !cur_d[1]; //RULE3
      o_at_zero   <= i_run && (cur_d == '0); //RULE5
      o_at_target <= (cur_d == i_target);
    end
  end
  // ==========================================
  // checks
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_edge_gap_min: assert property (step && i_ce |=> //RULE3
    gap_q == GAP_W'(EDGE_GAP_CYC - 1)) else $error("edge gap not loaded");
  a_one_chan_moves: assert property (##1 //RULE3
    !($changed(o_a) && $changed(o_b))) else $error("a and b moved together");
  a_zero_phase: assert property (o_at_zero |-> o_a && o_b) //RULE5
    else $error("zero outside a=b=1");
  c_reverse: cover property (step && up ##[1:200] step && !up);
endmodule
`default_nettype wire

// file: tb/eeo_encoder_emulation_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the encoder emulation block
module eeo_encoder_emulation_bench import eeo_pkg::*;;
  logic i_core_clk, i_rst, i_ce, i_pos_valid, o_pos_ready, i_sine_zero;
  logic i_feedback_is_encoder, i_comm_track, i_homing_done, i_multi_turn;
  logic i_serial_code_select, i_serial_clock_rate_select;
  logic i_serial_clock_invert, i_ssi_clk, o_ssi_data, o_ssi_busy;
  logic o_enc_a, o_enc_b, o_enc_zero, o_line_count_bad;
  logic [ANGLE_W-1:0]  i_pos_angle, i_zero_marker_offset;
  logic [TURNS_W-1:0]  i_pos_turns;
  logic [PHASE_W-1:0]  i_sine_phase;
  logic [1:0]          i_encoder_output_function;
  logic [5:0]          i_resolver_poles;
  logic [LINES_W-1:0]  i_line_count;
  logic [INTERP_W-1:0] i_interp_lines;
  int                  err_total;
  int                  num_checks;

  eeo_encoder_emulation uut (
    .i_core_clk, .i_rst, .i_ce, .i_pos_valid, .i_pos_angle, .i_pos_turns,
    .o_pos_ready, .i_sine_phase, .i_sine_zero, .i_encoder_output_function,
    .i_feedback_is_encoder, .i_resolver_poles, .i_comm_track,
    .i_homing_done, .i_line_count, .i_interp_lines, .i_zero_marker_offset,
    .i_multi_turn, .i_serial_code_select, .i_serial_clock_rate_select,
    .i_serial_clock_invert, .i_ssi_clk, .o_ssi_data, .o_ssi_busy,
    .o_enc_a, .o_enc_b, .o_enc_zero, .o_line_count_bad
  );
  eeo_ssi_master sm (
    .i_ssi_data(o_ssi_data),
    .i_invert(i_serial_clock_invert),
    .o_ssi_clk(i_ssi_clk)
  );

  always #4 i_core_clk = ~i_core_clk;

  // ==========================================
  // shared helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [23:0] gray(input logic [23:0] b);
    return b ^ (b >> 1);
  endfunction

  // offer one sample, hold it until an edge sees ready high
  task automatic push(input logic [23:0] a, input logic [11:0] t);
    int k;
    i_pos_angle = a;
    i_pos_turns = t;
    i_pos_valid = 1'h1;
    for (k = 0; k < 8000 && o_pos_ready !== 1'h1; k++) cyc(1);
    chk("sample_taken", 24'h1, 24'(k < 8000));
    cyc(1);
    i_pos_valid = 1'h0;
    cyc(1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic range_test();
    logic [19:0] lv [7];
    logic        en [7];
    logic        bd [7];
    lv = '{20'h0, 20'h400, 20'h401, 20'h1000, 20'h1001, 20'h80000, 20'h3000};
    en = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
    bd = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    i_encoder_output_function = FN_INCR;
    for (int i = 0; i < 7; i++) begin
      i_feedback_is_encoder = en[i];
      i_line_count = lv[i];
      cyc(8);
      chk("line_bad", 24'(bd[i]), 24'(o_line_count_bad));
      if (bd[i]) begin
        chk("held_ab", 24'h0, 24'({o_enc_a, o_enc_b}));
      end
    end
    $display("range test done");
  endtask

  task automatic quad_test();
    logic [1:0] seq [4];
    seq = '{2'h3, 2'h1, 2'h0, 2'h2};
    i_feedback_is_encoder = 1'h0;
    i_line_count = 20'h00001;
    for (int i = 0; i < 4; i++) begin
      push(24'(i) << 22, 12'h000);
      cyc(80);
      chk("quad_ab", 24'(seq[i]), 24'({o_enc_a, o_enc_b}));
      chk("zero_mark", 24'(i == 0), 24'(o_enc_zero));
    end
    i_zero_marker_offset = 24'h400000;
    push(24'h400000, 12'h000);
    cyc(100);
    chk("offset_zero", 24'h7, 24'({o_enc_a, o_enc_b, o_enc_zero}));
    i_zero_marker_offset = 24'h000000;
    $display("quadrature test done");
  endtask

  task automatic interp_test();
    i_encoder_output_function = FN_INTERP;
    i_interp_lines = 8'h04;
    i_sine_phase = 16'h1000;
    cyc(250);
    chk("interp_ab", 24'h1, 24'({o_enc_a, o_enc_b}));
    i_sine_zero = 1'h1;
    cyc(8);
    chk("zero_pass", 24'h1, 24'(o_enc_zero));
    i_sine_zero = 1'h0;
    cyc(8);
    chk("zero_pass", 24'h0, 24'(o_enc_zero));
    i_interp_lines = 8'h81;
    cyc(8);
    chk("interp_bad", 24'h1, 24'(o_line_count_bad));
    i_interp_lines = 8'h04;
    $display("interpolation test done");
  endtask

  // quadrature steps slowly, so the buffer must refuse and then recover
  task automatic fill_test();
    int  k;
    logic tk;
    logic [1:0] ab;
    i_encoder_output_function = FN_INCR;
    i_line_count = 20'h00040;
    i_pos_angle = 24'h800000;
    i_pos_valid = 1'h1;
    for (k = 0; k < 12; k++) begin
      tk = o_pos_ready;
      cyc(1);
      if (tk) begin
        i_pos_angle = i_pos_angle ^ 24'h800000;
      end
    end
    chk("full_ready", 24'h0, 24'(o_pos_ready));
    // clock enable low must freeze the pulse train mid-walk
    ab = {o_enc_a, o_enc_b};
    i_ce = 1'h0;
    cyc(60);
    chk("ce_freeze", 24'(ab), 24'({o_enc_a, o_enc_b}));
    i_ce = 1'h1;
    i_pos_valid = 1'h0;
    for (k = 0; k < 20000 && o_pos_ready !== 1'h1; k++) cyc(1);
    chk("drained_ready", 24'h1, 24'(o_pos_ready));
    $display("buffer test done");
  endtask

  // cfg: code, multi, encoder, comm track, homed, fast rate, invert
  task automatic ssi_case(input logic [6:0] cfg, input logic [5:0] p,
                          input logic [23:0] a, input logic [11:0] t,
                          input logic [23:0] e, input int hp);
    logic [23:0] w;
    int          n;
    int          mono;
    i_encoder_output_function = FN_SSI;
    {i_serial_code_select, i_multi_turn, i_feedback_is_encoder,
     i_comm_track, i_homing_done, i_serial_clock_rate_select,
     i_serial_clock_invert} = cfg;
    i_resolver_poles = p;
    // a change of invert may look like a frame start, let it expire
    cyc(4);
    for (n = 0; n < 2000 && o_ssi_busy !== 1'h0; n++) cyc(1);
    push(a, t);
    cyc(20);
    sm.read_frame(hp, w);
    chk("ssi_word", e, w);
    for (n = 0; n < 2000 && o_ssi_busy !== 1'h0; n++) cyc(1);
    mono = cfg[1] ? MONO_FAST_CYC : MONO_SLOW_CYC;
    n = n + hp / 4;
    chk("monoflop", 24'h1, 24'(n >= mono && n <= mono + 8));
    chk("idle_data", 24'h1, 24'(o_ssi_data));
    $display("serial case done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    {i_core_clk, i_ce, i_rst, i_pos_valid, i_sine_zero} = 5'h0c;
    {i_feedback_is_encoder, i_comm_track, i_homing_done} = 3'h0;
    {i_multi_turn, i_serial_code_select} = 2'h0;
    {i_serial_clock_rate_select, i_serial_clock_invert} = 2'h0;
    i_pos_angle = 24'h000000;
    i_zero_marker_offset = 24'h000000;
    i_pos_turns = 12'h000;
    i_sine_phase = 16'h0000;
    i_encoder_output_function = FN_OFF;
    i_resolver_poles = 6'h02;
    i_line_count = 20'h00001;
    i_interp_lines = 8'h04;
    err_total = 0;
    num_checks = 0;
    cyc(2);
    chk("reset_out", 24'h40, 24'({o_ssi_data, o_ssi_busy, o_enc_a,
        o_enc_b, o_enc_zero, o_pos_ready, o_line_count_bad}));
    i_rst = 1'h0;
    cyc(3);
    chk("ready_up", 24'h1, 24'(o_pos_ready));
    range_test();
    quad_test();
    interp_test();
    fill_test();
    ssi_case(7'h40, 6'h02, 24'habc123, 12'h5a5, 24'h000abc, 32);
    ssi_case(7'h23, 6'h02, 24'h123456, 12'h7e1, gray(24'h7e1123), 32);
    ssi_case(7'h42, 6'h04, 24'h9abcde, 12'h000, 24'h000357, 64);
    ssi_case(7'h42, 6'h06, 24'h600000, 12'h000, 24'h000200, 32);
    ssi_case(7'h58, 6'h02, 24'h456789, 12'h000, 24'hfff456, 32);
    ssi_case(7'h5c, 6'h02, 24'h456789, 12'h000, 24'h000456, 32);
    ssi_case(7'h01, 6'h02, 24'h456789, 12'h000, gray(24'h000456), 32);
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    #600000;
    err_total++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire

// file: tb/eeo_ssi_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// serial position evaluator at the far side
module eeo_ssi_master (
  input  wire logic i_ssi_data,
  input  wire logic i_invert,
  output logic      o_ssi_clk
);
  logic lvl;
  // clock stands high between frames, low when i_invert is set
  assign o_ssi_clk = lvl ^ i_invert;
  initial lvl = 1'h1;
  // caller keeps the monoflop gap before the next frame
  task automatic read_frame(input int hp, output logic [23:0] word);
    word = 24'h000000;
    lvl = 1'h0;
    #(hp);
    for (int i = 0; i < 24; i++) begin
      lvl = 1'h1;
      #(hp);
      if (i < 23) begin
        lvl = 1'h0;
      end
      // sample late in the period, data moves a few cycles after a rise
      #(hp - 2);
      word = {word[22:0], i_ssi_data};
      #2;
    end
  endtask
endmodule
`default_nettype wire
